// [design/emd_pkg.sv]
package emd_pkg;
   // ------------------------------------------------------------
   // Header layout
   // ------------------------------------------------------------
   localparam int KIND_LSB = 24;
   localparam int KIND_W = 4;
   localparam int PAYLOAD_LSB = 16;
   localparam int BODY_LSB = 8;
   localparam int COUNT_W = 8;

   // Message kinds
   localparam logic [3:0] KIND_LED = 4'h0;
   localparam logic [3:0] KIND_SVC1 = 4'h1;
   localparam logic [3:0] KIND_SVC2 = 4'h2;
   localparam logic [3:0] KIND_GPIO = 4'h3;

   // Indicator codes
   localparam logic [2:0] IND_OFF = 3'h0;
   localparam logic [2:0] IND_ON = 3'h1;

   // LED addressing bytes
   localparam int CTRL_PORT_W = 5;
   localparam int WIDE_BIT = 5;
   localparam int MULT_PORT_W = 4;
   localparam int NUM_IND = 3;

   // Reset values
   localparam logic [7:0] CNT_RST = 8'h00;

   typedef enum logic [2:0] {
      EMD_IDLE, EMD_LED0, EMD_LED1, EMD_LED2, EMD_LED3, EMD_BODY, EMD_DATA
   } emd_state_t;
endpackage

// [design/emd_decoder.sv]
// Function
// RULE1: Type field: LED, services one, services two, GPIO; rest reserved. GPIO is flagged and dropped here like a reserved kind.
// RULE2: Message size counts body bytes without header; zero is invalid.
// RULE3: Data size counts trailing data bytes; zero when none.
// RULE4: Indicator codes: 000 off, 001 on, 010/011 reserved, 1xx vendor.
// RULE5: Byte one low nibble is multiplier port; upper nibble reserved.
// RULE6: Software writes zero multiplier port when no multiplier present.
// RULE7: Byte zero bits 4:0 are controller port; bits 7:6 reserved.
// RULE8: Bit 5 set means enclosure-wide vendor command, port ignored.
// RULE9: Bit 5 clear applies value only to selected controller port.
// RULE10: Services-one message is one command block, opcode byte first.
// RULE11: Software places services-one data right after the command block.
// RULE12: Services-one command block length comes from message size.
// RULE13: Services-one data length comes from data size.
// RULE14: Services-two message is one command block, opcode byte first.
// RULE15: Software places services-two data right after the command block.
// RULE16: Services-two lengths come from message and data size fields.
// RULE17: Reserved addressing bits are ignored, message not rejected.
`timescale 1ns/1ps
module emd_decoder (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic hdr_valid,
   input wire logic [31:0] hdr_word,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic busy,
   output logic hdr_error,
   output logic [3:0] message_kind,
   output logic [7:0] body_byte_count,
   output logic [7:0] payload_byte_count,
   output logic led_update,
   output logic led_wide,
   output logic [4:0] led_ctrl_port,
   output logic [3:0] led_mult_port,
   output logic [15:0] indicator_value,
   output logic [2:0] ind_on,
   output logic [2:0] ind_off,
   output logic [2:0] ind_vendor,
   output logic ep_valid,
   output logic [7:0] ep_byte,
   output logic ep_first,
   output logic ep_is_data,
   output logic ep_last
);
   import emd_pkg::*;

   // All checks sample on the core clock and sleep through reset
   default clocking emd_cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Classify one code; reserved 010/011 give class zero, no flag set
   function automatic logic [1:0] ind_class(input logic [2:0] c);
      return (c == IND_OFF) ? 2'h1 : (c == IND_ON) ? 2'h2 : c[2] ? 2'h3 : 2'h0;
   endfunction

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   emd_state_t state_r, state_nxt;
   logic [7:0] remain_r, remain_nxt, payload_byte_count_r, payload_byte_count_nxt, body_byte_count_r, body_byte_count_nxt;
   logic [7:0] b0_r, b0_nxt, vlo_r, vlo_nxt, epb_r, epb_nxt;
   logic [3:0] kind_r, kind_nxt, mult_r, mult_nxt, mport_r, mport_nxt;
   logic err_r, err_nxt, upd_r, upd_nxt, wide_r, wide_nxt, busy_r, busy_nxt;
   logic [4:0] cport_r, cport_nxt;
   logic [15:0] val_r, val_nxt;
   logic [2:0] on_r, on_nxt, off_r, off_nxt, ven_r, ven_nxt;
   logic epv_r, epv_nxt, epf_r, epf_nxt, epd_r, epd_nxt, epl_r, epl_nxt;
   logic [1:0] cls;

   // Next-state and output decode
   always_comb begin
      state_nxt = state_r;
      remain_nxt = remain_r;
      payload_byte_count_nxt = payload_byte_count_r;
      kind_nxt = kind_r;
      body_byte_count_nxt = body_byte_count_r;
      err_nxt = err_r;
      b0_nxt = b0_r;
      mult_nxt = mult_r;
      vlo_nxt = vlo_r;
      upd_nxt = 1'b0;
      wide_nxt = wide_r;
      cport_nxt = cport_r;
      mport_nxt = mport_r;
      val_nxt = val_r;
      on_nxt = on_r;
      off_nxt = off_r;
      ven_nxt = ven_r;
      epv_nxt = 1'b0;
      epf_nxt = 1'b0;
      epd_nxt = 1'b0;
      epl_nxt = 1'b0;
      epb_nxt = epb_r;
      cls = 2'h0;
      case (state_r)
         EMD_IDLE: begin
            if (hdr_valid) begin
               kind_nxt = hdr_word[KIND_LSB +: KIND_W]; // see RULE1
               body_byte_count_nxt = hdr_word[BODY_LSB +: COUNT_W]; // see RULE2
               payload_byte_count_nxt = hdr_word[PAYLOAD_LSB +: COUNT_W]; // see RULE3
               remain_nxt = hdr_word[BODY_LSB +: COUNT_W];
               err_nxt = 1'b0;
               // Zero size or reserved/GPIO kind: message dropped
               if (hdr_word[BODY_LSB +: COUNT_W] == CNT_RST) begin
                  err_nxt = 1'b1; // see RULE2
               end else if (hdr_word[KIND_LSB +: KIND_W] == KIND_LED) begin
                  state_nxt = EMD_LED0;
               end else if (hdr_word[KIND_LSB +: KIND_W] == KIND_SVC1 ||
                            hdr_word[KIND_LSB +: KIND_W] == KIND_SVC2) begin
                  state_nxt = EMD_BODY; // see RULE10, RULE14
               end else begin
                  err_nxt = 1'b1; // see RULE1
               end
            end
         end
         EMD_LED0: if (byte_valid) begin
            b0_nxt = byte_data;
            state_nxt = EMD_LED1;
         end
         EMD_LED1: if (byte_valid) begin
            mult_nxt = byte_data[MULT_PORT_W-1:0]; // see RULE5, RULE17
            state_nxt = EMD_LED2;
         end
         EMD_LED2: if (byte_valid) begin
            vlo_nxt = byte_data;
            state_nxt = EMD_LED3;
         end
         EMD_LED3: if (byte_valid) begin
            upd_nxt = 1'b1;
            val_nxt = {byte_data, vlo_r};
            wide_nxt = b0_r[WIDE_BIT]; // see RULE8, RULE9
            // Port field is only meaningful for slot updates
            cport_nxt = b0_r[WIDE_BIT] ? 5'h00 :
                        b0_r[CTRL_PORT_W-1:0]; // see RULE7, RULE8
            mport_nxt = mult_r; // see RULE5
            for (int i = 0; i < NUM_IND; i++) begin
               cls = ind_class(val_nxt[3*i +: 3]); // see RULE4
               on_nxt[i] = (cls == 2'h2);
               off_nxt[i] = (cls == 2'h1);
               ven_nxt[i] = (cls == 2'h3);
            end
            // Bytes past the fourth are not used by an LED message
            state_nxt = EMD_IDLE;
         end
         EMD_BODY: if (byte_valid) begin
            epv_nxt = 1'b1;
            epb_nxt = byte_data;
            epf_nxt = (remain_r == body_byte_count_r); // Opcode byte first
            remain_nxt = remain_r - 8'h01; // see RULE12, RULE16
            if (remain_r == 8'h01) begin
               if (payload_byte_count_r == CNT_RST) begin
                  epl_nxt = 1'b1;
                  state_nxt = EMD_IDLE;
               end else begin
                  remain_nxt = payload_byte_count_r; // see RULE11, RULE15
                  state_nxt = EMD_DATA;
               end
            end
         end
         EMD_DATA: if (byte_valid) begin
            epv_nxt = 1'b1;
            epd_nxt = 1'b1;
            epb_nxt = byte_data;
            remain_nxt = remain_r - 8'h01; // see RULE13, RULE16
            if (remain_r == 8'h01) begin
               epl_nxt = 1'b1;
               state_nxt = EMD_IDLE;
            end
         end
         default: state_nxt = EMD_IDLE;
      endcase
      busy_nxt = (state_nxt != EMD_IDLE); // Registered so busy is a flop
   end

   // Register stage, synchronous active-low reset
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state_r <= EMD_IDLE;
         busy_r <= 1'b0;
         remain_r <= CNT_RST;
         payload_byte_count_r <= CNT_RST;
         body_byte_count_r <= CNT_RST;
         kind_r <= 4'h0;
         err_r <= 1'b0;
         b0_r <= 8'h00;
         mult_r <= 4'h0;
         vlo_r <= 8'h00;
         upd_r <= 1'b0;
         wide_r <= 1'b0;
         cport_r <= 5'h00;
         mport_r <= 4'h0;
         val_r <= 16'h0000;
         on_r <= 3'h0;
         off_r <= 3'h0;
         ven_r <= 3'h0;
         epv_r <= 1'b0;
         epf_r <= 1'b0;
         epd_r <= 1'b0;
         epl_r <= 1'b0;
         epb_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         busy_r <= busy_nxt;
         remain_r <= remain_nxt;
         payload_byte_count_r <= payload_byte_count_nxt;
         body_byte_count_r <= body_byte_count_nxt;
         kind_r <= kind_nxt;
         err_r <= err_nxt;
         b0_r <= b0_nxt;
         mult_r <= mult_nxt;
         vlo_r <= vlo_nxt;
         upd_r <= upd_nxt;
         wide_r <= wide_nxt;
         cport_r <= cport_nxt;
         mport_r <= mport_nxt;
         val_r <= val_nxt;
         on_r <= on_nxt;
         off_r <= off_nxt;
         ven_r <= ven_nxt;
         epv_r <= epv_nxt;
         epf_r <= epf_nxt;
         epd_r <= epd_nxt;
         epl_r <= epl_nxt;
         epb_r <= epb_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all from flops
   // ------------------------------------------------------------
   assign busy = busy_r;
   assign hdr_error = err_r;
   assign message_kind = kind_r;
   assign body_byte_count = body_byte_count_r;
   assign payload_byte_count = payload_byte_count_r;
   assign led_update = upd_r;
   assign led_wide = wide_r;
   assign led_ctrl_port = cport_r;
   assign led_mult_port = mport_r;
   assign indicator_value = val_r;
   assign ind_on = on_r;
   assign ind_off = off_r;
   assign ind_vendor = ven_r;
   assign ep_valid = epv_r;
   assign ep_byte = epb_r;
   assign ep_first = epf_r;
   assign ep_is_data = epd_r;
   assign ep_last = epl_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_zero_size_err: assert property ( // see RULE2
      state_r == EMD_IDLE && hdr_valid && hdr_word[15:8] == 8'h00
      |=> err_r && state_r == EMD_IDLE)
      else $error("zero message size not flagged");
   a_reserved_kind: assert property ( // see RULE1
      state_r == EMD_IDLE && hdr_valid && hdr_word[27:24] > 4'h2
      |=> err_r && state_r == EMD_IDLE)
      else $error("reserved kind started a transfer");
   a_wide_port_zero: assert property ( // see RULE8
      upd_r && wide_r |-> cport_r == 5'h00)
      else $error("wide command carried a port");
   a_slot_port: assert property ( // see RULE9
      state_r == EMD_LED3 && byte_valid && !b0_r[5]
      |=> upd_r && cport_r == $past(b0_r[4:0]))
      else $error("slot port mismatch");
   a_mult_port: assert property ( // see RULE5
      state_r == EMD_LED3 && byte_valid |=> mport_r == $past(mult_r))
      else $error("multiplier port mismatch");
   a_ind_off: assert property ( // see RULE4
      upd_r |-> off_r[0] == (val_r[2:0] == 3'h0))
      else $error("off code misdecoded");
   // The gap cycle matches a source that waits one cycle after the header
   a_first_opcode: assert property ( // see RULE10
      state_r == EMD_IDLE && hdr_valid && hdr_word[15:8] != 8'h00 &&
      (hdr_word[27:24] == 4'h1 || hdr_word[27:24] == 4'h2)
      ##1 !byte_valid ##1 byte_valid
      |=> ep_valid && ep_first && !ep_is_data)
      else $error("opcode byte not first");
   a_body_len: assert property ( // see RULE12
      state_r == EMD_IDLE && hdr_valid && hdr_word[15:8] == 8'h01 &&
      hdr_word[23:16] == 8'h00 && hdr_word[27:24] == 4'h1
      ##1 !byte_valid ##1 byte_valid
      |=> ep_last && state_r == EMD_IDLE)
      else $error("single byte block not ended");
   a_data_flag: assert property ( // see RULE13
      state_r == EMD_DATA && byte_valid |=> ep_valid && ep_is_data)
      else $error("data byte not marked");
   a_reserved_ignored: assert property ( // see RULE17
      state_r == EMD_LED1 && byte_valid
      |=> state_r == EMD_LED2 && mult_r == $past(byte_data[3:0]))
      else $error("reserved bits rejected");
   c_led_msg: cover property (upd_r);
   c_wide_msg: cover property (upd_r && wide_r);
   c_data_end: cover property (ep_last && ep_is_data);
   c_bad_hdr: cover property (err_r);
endmodule

// [bench/emd_proc_model.sv]
`timescale 1ns/1ps
module emd_proc_model (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ep_valid,
   input wire logic [7:0] ep_byte,
   input wire logic ep_first,
   input wire logic ep_is_data,
   input wire logic ep_last
);
   // ------------------------------------------------------------
   // Receive log of the enclosure processor
   // ------------------------------------------------------------
   logic [10:0] rx_q[$];

   // One byte per pulse; the link offers no stall to the decoder
   always @(posedge core_clk) begin
      if (!rstn) begin
         rx_q.delete();
      end else if (ep_valid) begin
         // Opcode byte first, then the data block behind it
         rx_q.push_back({ep_first, ep_is_data, ep_last, ep_byte});
      end
   end
endmodule

// [bench/test_enclosure_msg_decoder.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
   mismatches++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module test_enclosure_msg_decoder;
   import emd_pkg::*;
   logic core_clk, rstn, hdr_valid, byte_valid;
   logic [31:0] hdr_word;
   logic [7:0] byte_data, b0, b1, bsz, dsz;
   logic [15:0] v;
   logic [3:0] k;
   logic busy, hdr_error, led_update, led_wide, ep_valid, ep_first;
   logic ep_is_data, ep_last;
   logic [3:0] message_kind, led_mult_port;
   logic [7:0] body_byte_count, payload_byte_count, ep_byte;
   logic [4:0] led_ctrl_port;
   logic [15:0] indicator_value;
   logic [2:0] ind_on, ind_off, ind_vendor;
   logic [7:0] q[$];
   logic [10:0] e;
   int mismatches, checked, cycles;

   emd_decoder uut (.core_clk(core_clk), .rstn(rstn),
      .hdr_valid(hdr_valid), .hdr_word(hdr_word), .byte_valid(byte_valid),
      .byte_data(byte_data), .busy(busy), .hdr_error(hdr_error),
      .message_kind(message_kind), .body_byte_count(body_byte_count),
      .payload_byte_count(payload_byte_count), .led_update(led_update),
      .led_wide(led_wide), .led_ctrl_port(led_ctrl_port),
      .led_mult_port(led_mult_port), .indicator_value(indicator_value),
      .ind_on(ind_on), .ind_off(ind_off), .ind_vendor(ind_vendor),
      .ep_valid(ep_valid), .ep_byte(ep_byte), .ep_first(ep_first),
      .ep_is_data(ep_is_data), .ep_last(ep_last));

   emd_proc_model model (.core_clk(core_clk), .rstn(rstn),
      .ep_valid(ep_valid), .ep_byte(ep_byte), .ep_first(ep_first),
      .ep_is_data(ep_is_data), .ep_last(ep_last));

   // ------------------------------------------------------------
   // Clock, timeout and verdict
   // ------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Whole run needs well under two thousand cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      if (mismatches == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Drivers and expectation helpers
   // ------------------------------------------------------------
   function automatic logic [8:0] ind_exp(input logic [15:0] val);
      logic [2:0] on, off, ven, c;
      for (int i = 0; i < 3; i++) begin
         c = val[3*i+:3];
         on[i] = (c == IND_ON);
         off[i] = (c == IND_OFF);
         ven[i] = c[2];
      end
      return {on, off, ven};
   endfunction

   // Reserved header bits are randomised; a bad header must stay idle
   task automatic send_hdr(input logic [3:0] kd, input logic [7:0] bs,
                           input logic [7:0] ds, input logic bad);
      logic [11:0] r;
      r = 12'($urandom);
      @(posedge core_clk);
      hdr_valid <= 1'b1;
      hdr_word <= {r[11:8], kd, ds, bs, r[7:0]};
      @(posedge core_clk);
      hdr_valid <= 1'b0;
      #1;
      `CHK(hdr_error, bad)
      `CHK(busy, ~bad)
      if (!bad) begin
         `CHK(message_kind, kd)
         `CHK(body_byte_count, bs)
         `CHK(payload_byte_count, ds)
      end
   endtask

   // Bytes go back to back, one per cycle
   task automatic send_bytes();
      foreach (q[i]) begin
         @(posedge core_clk);
         byte_valid <= 1'b1;
         byte_data <= q[i];
      end
      @(posedge core_clk);
      byte_valid <= 1'b0;
      #1;
      `CHK(busy, 1'b0)
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'h072945e9));
      rstn = 1'b0;
      hdr_valid = 1'b0;
      byte_valid = 1'b0;
      hdr_word = 32'h0000_0000;
      byte_data = 8'h00;
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      #1;
      `CHK({busy, hdr_error, led_update, ep_valid, message_kind}, 8'h00)
      // Reserved kinds and the unsupported GPIO kind, then zero size
      for (int i = 3; i < 16; i++)
         send_hdr(4'(i), 8'h04, 8'h00, 1'b1);
      send_hdr(KIND_LED, 8'h00, 8'h00, 1'b1);
      send_hdr(KIND_SVC1, 8'h00, 8'h03, 1'b1);
      // LED messages with random reserved bits; first one enclosure-wide
      for (int i = 0; i < 12; i++) begin
         b0 = (i == 0) ? 8'h3f : 8'($urandom);
         b1 = (i % 3 == 1) ? {4'($urandom), 4'h0} : 8'($urandom);
         v = 16'($urandom);
         send_hdr(KIND_LED, 8'h04, 8'h00, 1'b0);
         q = '{b0, b1, v[7:0], v[15:8]};
         send_bytes();
         `CHK(led_update, 1'b1)
         `CHK(led_wide, b0[5])
         `CHK(led_ctrl_port, b0[5] ? 5'h00 : b0[4:0])
         `CHK(led_mult_port, b1[3:0])
         `CHK(indicator_value, v)
         `CHK({ind_on, ind_off, ind_vendor}, ind_exp(v))
      end
      // Reset in mid-message drops it; the next header is still taken
      send_hdr(KIND_SVC2, 8'h03, 8'h00, 1'b0);
      @(posedge core_clk);
      rstn <= 1'b0;
      @(posedge core_clk);
      rstn <= 1'b1;
      #1;
      `CHK({busy, hdr_error, ep_valid, message_kind}, 7'h00)
      // Services messages of both kinds, lengths from the header
      for (int i = 0; i < 16; i++) begin
         k = i[0] ? KIND_SVC2 : KIND_SVC1;
         bsz = (i < 2) ? 8'h01 : 8'(1 + $urandom % 8);
         dsz = (i < 2) ? 8'h00 : 8'($urandom % 6);
         q = {};
         repeat (bsz + dsz) q.push_back(8'($urandom));
         send_hdr(k, bsz, dsz, 1'b0);
         if (i == 3) begin
            // A header offered mid-message must be ignored
            @(posedge core_clk);
            hdr_valid <= 1'b1;
            hdr_word <= 32'h0000_0000;
            @(posedge core_clk);
            hdr_valid <= 1'b0;
            #1;
            `CHK({busy, hdr_error, message_kind}, {2'b10, k})
         end
         send_bytes();
         @(posedge core_clk);
         #1;
         `CHK(model.rx_q.size(), q.size())
         foreach (q[j]) begin
            e = {j == 0, j >= bsz, j == q.size() - 1, q[j]};
            `CHK(model.rx_q[j], e)
         end
         model.rx_q.delete();
      end
      give_verdict();
   end
endmodule
